// ===== acm_pkg.sv
// Purpose: Constants for the converter configuration and mode control block
// Assumes: APB slave with 32-bit data, 12-bit byte address, one word per register
// Notes: Per-channel registers sit in blocks of eight words, one per analog input
//
// Function
// - Active-low reset input starts full reset
// - Device held in reset while input low
// - Software reset available over register bus
// - Configuration registers reachable only in configuration mode
// - Start in configuration mode after any reset
// - Scratch register stores value, affects nothing
// - Setup mode bit one enters conversion mode
// - Standard sequencer enable reads one after reset
// - Advanced sequencer when enable zero, count nonzero
// - Command mode when both zero; cycle bit chooses
// - Setup bits act in same write as mode
// - Standard sequencer: channel zero config applies everywhere
// - Channel config holds alert, polarity, pairing, highZ, ratio
// - Enabled channels compared against own upper, lower
// - Alert-mode bit enables hysteresis of channel amount
// - Autocycle off after reset, set by own register
// - Regulator enable zero turns regulator off
// - Status error bit flags refused configuration writes
// - Clamp status shows overvoltage channels
// - Conversion mode transfers change no configuration
// - Mode command in conversion returns to configuration
// - Standard pass converts each enabled channel once
package acm_pkg;
	localparam logic [11:0] ADDR_SETUP = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_SCRATCH = 12'h008;
	localparam logic [11:0] ADDR_SEQUENCER_CONTROL = 12'h00C;
	localparam logic [11:0] ADDR_STD_CHANS = 12'h010;
	localparam logic [11:0] ADDR_AUTOCYCLE = 12'h014;
	localparam logic [11:0] ADDR_CLAMP = 12'h018;
	localparam logic [11:0] ADDR_SOFT_RESET = 12'h01C;
	localparam logic [11:0] ADDR_COMMAND = 12'h020;
	localparam logic [11:0] ADDR_ALERT = 12'h024;
	localparam logic [11:0] BASE_CHAN_CFG = 12'h040;
	localparam logic [11:0] BASE_UPPER = 12'h060;
	localparam logic [11:0] BASE_LOWER = 12'h080;
	localparam logic [11:0] BASE_HYST = 12'h0A0;
	localparam logic [11:0] BASE_SLOT = 12'h0C0;
	localparam logic [11:0] BASE_OFFSET = 12'h0E0;
	localparam logic [11:0] BASE_GAIN = 12'h100;
	// Setup register fields
	localparam int SETUP_CONV_BIT = 0;
	localparam int SETUP_REG_EN_BIT = 1;
	localparam int SETUP_ALERT_HYST_BIT = 2;
	localparam int SETUP_CYCLE_BIT = 3;
	localparam logic [3:0] SETUP_RESET = 4'h2;
	// Sequencer control fields
	localparam int SEQ_STD_BIT = 7;
	localparam logic [7:0] SEQUENCER_CONTROL_RESET = 8'h80;
	localparam logic [7:0] STD_CHANS_RESET = 8'hFF;
	localparam logic [3:0] AUTOCYCLE_RESET = 4'h0;
	localparam logic [15:0] UPPER_RESET = 16'hFFFF;
	localparam logic [15:0] LOWER_RESET = 16'h0000;
	localparam logic [7:0] HYST_RESET = 8'h00;
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	localparam logic [15:0] GAIN_RESET = 16'h8000;
	localparam logic [5:0] CHAN_CFG_RESET = 6'h00;
	// Channel config fields
	localparam int CFG_ALERT_BIT = 0;
	localparam int CFG_POLARITY_BIT = 1;
	localparam int CFG_PAIRING_BIT = 2;
	localparam int CFG_HIGHZ_BIT = 3;
	// Commands sent in a conversion frame; values are arbitrary
	localparam logic [4:0] CMD_CONFIG_MODE = 5'h0A;
	localparam logic [1:0] CMD_CHAN_PREFIX = 2'h2;
	localparam logic [31:0] SOFT_RESET_KEY = 32'h0000005A;

	typedef enum logic [1:0] {
		SEQ_STANDARD = 2'b00,
		SEQ_ADVANCED = 2'b01,
		SEQ_TWO_CYCLE = 2'b10,
		SEQ_ONE_CYCLE = 2'b11
	} acm_seq_mode_type;
endpackage

// ===== acm_config_mode_control.sv
// Purpose: Register bank, operating mode and channel sequencing for the converter
// Assumes: APB master on ref_clk; conversion start and clamp levels arrive from pins
// Notes: Conversion results arrive on ref_clk from the converter core
`timescale 1ns/1ns
module acm_config_mode_control (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from outside the clock domain
	input wire logic convStartPin,
	input wire logic [7:0] clampPins,
	// Converter core results
	input wire logic resultValid,
	input wire logic [15:0] resultData,
	// Device controls
	output logic convMode,
	output logic regulatorOn,
	output logic [1:0] seqMode,
	output logic [2:0] muxChannel,
	output logic [5:0] activeConfig,
	output logic autocycleOn,
	output logic [2:0] autocycleRate,
	output logic alertOut
);
	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic inBlock(input logic [11:0] addr, input logic [11:0] base);
		inBlock = (addr[11:5] == base[11:5]);
	endfunction

	function automatic logic [2:0] nextEnabled(input logic [7:0] mask, input logic [2:0] cur);
		logic [2:0] idx;
		nextEnabled = cur;
		for (int k = 8; k >= 1; k--) begin
			idx = 3'(cur + 3'(k));
			if (mask[idx]) begin
				nextEnabled = idx;
			end
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [3:0] setup_r;
	logic statusErr_r;
	logic [31:0] scratch_r;
	logic [7:0] seqCtrl_r;
	logic [7:0] stdChans_r;
	logic [3:0] autocycle_r;
	logic [5:0] chanCfg_r [8];
	logic [15:0] upper_r [8];
	logic [15:0] lower_r [8];
	logic [7:0] hyst_r [8];
	logic [2:0] slot_r [8];
	logic [15:0] offset_r [8];
	logic [15:0] gain_r [8];
	logic [7:0] alertState_r;
	logic softRst_r;
	logic [2:0] slotIdx_r;
	logic [2:0] pendChan_r;
	logic pendValid_r;
	logic [2:0] convChan_r;
	logic [7:0] clampStable_r;
	logic convStable_r;
	logic convPrev_r;
	logic regRst;
	logic access;
	logic wrEn;
	logic cfgAddr;
	logic mapped;
	logic refuse;
	logic [2:0] idx;
	logic [3:0] slotCount;
	logic [31:0] rdValue;
	logic cmdWrite;
	logic convEdge;
	acm_pkg::acm_seq_mode_type seqMode_nxt;

	// Hardware reset holds everything while low; software reset lasts one cycle
	assign regRst = !rst_n || softRst_r;
	assign access = psel && penable;
	assign wrEn = access && pready && pwrite;
	assign idx = paddr[4:2];
	assign slotCount = seqCtrl_r[3:0];
	assign cmdWrite = wrEn && convMode && (paddr == acm_pkg::ADDR_COMMAND);

	// ****************************************
	// Address map
	// ****************************************
	always_comb begin
		cfgAddr = 1'b1;
		mapped = 1'b1;
		case (paddr)
			acm_pkg::ADDR_SETUP: rdValue = {28'h0, setup_r};
			acm_pkg::ADDR_STATUS: begin
				rdValue = {30'h0, convMode, statusErr_r};
				cfgAddr = 1'b0;
			end
			acm_pkg::ADDR_SCRATCH: rdValue = scratch_r;
			acm_pkg::ADDR_SEQUENCER_CONTROL: rdValue = {24'h0, seqCtrl_r};
			acm_pkg::ADDR_STD_CHANS: rdValue = {24'h0, stdChans_r};
			acm_pkg::ADDR_AUTOCYCLE: rdValue = {28'h0, autocycle_r};
			acm_pkg::ADDR_CLAMP: rdValue = {24'h0, clampStable_r};
			acm_pkg::ADDR_SOFT_RESET: rdValue = 32'h0;
			acm_pkg::ADDR_COMMAND: begin
				rdValue = 32'h0;
				cfgAddr = 1'b0;
			end
			acm_pkg::ADDR_ALERT: rdValue = {24'h0, alertState_r};
			default: begin
				if (inBlock(paddr, acm_pkg::BASE_CHAN_CFG)) begin
					rdValue = {26'h0, chanCfg_r[idx]};
				end else if (inBlock(paddr, acm_pkg::BASE_UPPER)) begin
					rdValue = {16'h0, upper_r[idx]};
				end else if (inBlock(paddr, acm_pkg::BASE_LOWER)) begin
					rdValue = {16'h0, lower_r[idx]};
				end else if (inBlock(paddr, acm_pkg::BASE_HYST)) begin
					rdValue = {24'h0, hyst_r[idx]};
				end else if (inBlock(paddr, acm_pkg::BASE_SLOT)) begin
					rdValue = {29'h0, slot_r[idx]};
				end else if (inBlock(paddr, acm_pkg::BASE_OFFSET)) begin
					rdValue = {16'h0, offset_r[idx]};
				end else if (inBlock(paddr, acm_pkg::BASE_GAIN)) begin
					rdValue = {16'h0, gain_r[idx]};
				end else begin
					rdValue = 32'h0;
					mapped = 1'b0;
				end
			end
		endcase
		// Unmapped, misaligned, read-only targets or config access while converting
		refuse = !mapped || (paddr[1:0] != 2'h0) || (cfgAddr && convMode)
			|| (pwrite && ((paddr == acm_pkg::ADDR_CLAMP) || (paddr == acm_pkg::ADDR_ALERT)))
			|| (!convMode && (paddr == acm_pkg::ADDR_COMMAND));
	end

	// ****************************************
	// APB answer: one wait state, data and error from flops
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= access && !pready;
			pslverr <= access && !pready && refuse;
			prdata <= (access && !pready && !pwrite && !refuse) ? rdValue : 32'h0;
		end
	end

	// ****************************************
	// Setup, mode and software reset
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (regRst) begin
			setup_r <= acm_pkg::SETUP_RESET;
		end else if (wrEn && !refuse && paddr == acm_pkg::ADDR_SETUP) begin
			setup_r <= pwdata[3:0];
		end else if (cmdWrite && pwdata[4:0] == acm_pkg::CMD_CONFIG_MODE) begin
			setup_r[acm_pkg::SETUP_CONV_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			softRst_r <= 1'b0;
		end else begin
			softRst_r <= wrEn && !refuse && paddr == acm_pkg::ADDR_SOFT_RESET
				&& pwdata == acm_pkg::SOFT_RESET_KEY;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (regRst) begin
			statusErr_r <= 1'b0;
		end else if (access && !pready && pwrite && refuse) begin
			statusErr_r <= 1'b1;
		end else if (wrEn && paddr == acm_pkg::ADDR_STATUS && pwdata[0]) begin
			statusErr_r <= 1'b0;
		end
	end

	// ****************************************
	// Plain configuration registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (regRst) begin
			scratch_r <= 32'h0;
			seqCtrl_r <= acm_pkg::SEQUENCER_CONTROL_RESET;
			stdChans_r <= acm_pkg::STD_CHANS_RESET;
			autocycle_r <= acm_pkg::AUTOCYCLE_RESET;
		end else if (wrEn && !refuse) begin
			case (paddr)
				acm_pkg::ADDR_SCRATCH: scratch_r <= pwdata;
				acm_pkg::ADDR_SEQUENCER_CONTROL: seqCtrl_r <= pwdata[7:0];
				acm_pkg::ADDR_STD_CHANS: stdChans_r <= pwdata[7:0];
				acm_pkg::ADDR_AUTOCYCLE: autocycle_r <= pwdata[3:0];
				default: begin
				end
			endcase
		end
	end

	// Per-channel registers, one generate slice per input
	for (genvar ch = 0; ch < 8; ch++) begin : g_chan
		logic hit;
		assign hit = wrEn && !refuse && (idx == 3'(ch));
		always_ff @(posedge ref_clk) begin
			if (regRst) begin
				chanCfg_r[ch] <= acm_pkg::CHAN_CFG_RESET;
				upper_r[ch] <= acm_pkg::UPPER_RESET;
				lower_r[ch] <= acm_pkg::LOWER_RESET;
				hyst_r[ch] <= acm_pkg::HYST_RESET;
				slot_r[ch] <= 3'h0;
				offset_r[ch] <= acm_pkg::OFFSET_RESET;
				gain_r[ch] <= acm_pkg::GAIN_RESET;
			end else if (hit) begin
				if (inBlock(paddr, acm_pkg::BASE_CHAN_CFG)) begin
					chanCfg_r[ch] <= pwdata[5:0];
				end
				if (inBlock(paddr, acm_pkg::BASE_UPPER)) begin
					upper_r[ch] <= pwdata[15:0];
				end
				if (inBlock(paddr, acm_pkg::BASE_LOWER)) begin
					lower_r[ch] <= pwdata[15:0];
				end
				if (inBlock(paddr, acm_pkg::BASE_HYST)) begin
					hyst_r[ch] <= pwdata[7:0];
				end
				if (inBlock(paddr, acm_pkg::BASE_SLOT)) begin
					slot_r[ch] <= pwdata[2:0];
				end
				if (inBlock(paddr, acm_pkg::BASE_OFFSET)) begin
					offset_r[ch] <= pwdata[15:0];
				end
				if (inBlock(paddr, acm_pkg::BASE_GAIN)) begin
					gain_r[ch] <= pwdata[15:0];
				end
			end
		end
	end

	// ****************************************
	// Pin synchronisers: three stages, change accepted when last two agree
	// ****************************************
	logic [8:0] sync1_r;
	logic [8:0] sync2_r;
	logic [8:0] sync3_r;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_r <= 9'h000;
			sync2_r <= 9'h000;
			sync3_r <= 9'h000;
		end else begin
			sync1_r <= {convStartPin, clampPins};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	for (genvar b = 0; b < 8; b++) begin : g_clamp
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				clampStable_r[b] <= 1'b0;
			end else if (sync2_r[b] == sync3_r[b]) begin
				clampStable_r[b] <= sync3_r[b];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			convStable_r <= 1'b0;
			convPrev_r <= 1'b0;
		end else begin
			if (sync2_r[8] == sync3_r[8]) begin
				convStable_r <= sync3_r[8];
			end
			convPrev_r <= convStable_r;
		end
	end
	assign convEdge = convStable_r && !convPrev_r;

	// ****************************************
	// Sequencing mode and channel stepping
	// ****************************************
	always_comb begin
		if (seqCtrl_r[acm_pkg::SEQ_STD_BIT]) begin
			seqMode_nxt = acm_pkg::SEQ_STANDARD;
		end else if (slotCount != 4'h0) begin
			seqMode_nxt = acm_pkg::SEQ_ADVANCED;
		end else if (setup_r[acm_pkg::SETUP_CYCLE_BIT]) begin
			seqMode_nxt = acm_pkg::SEQ_ONE_CYCLE;
		end else begin
			seqMode_nxt = acm_pkg::SEQ_TWO_CYCLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (regRst) begin
			muxChannel <= 3'h0;
			slotIdx_r <= 3'h0;
			pendChan_r <= 3'h0;
			pendValid_r <= 1'b0;
			convChan_r <= 3'h0;
		end else if (!convMode) begin
			slotIdx_r <= 3'h0;
			pendValid_r <= 1'b0;
			muxChannel <= (seqMode_nxt == acm_pkg::SEQ_ADVANCED) ? slot_r[0]
				: nextEnabled(stdChans_r, 3'h7);
		end else if (cmdWrite && pwdata[4:3] == acm_pkg::CMD_CHAN_PREFIX
			&& seqMode_nxt == acm_pkg::SEQ_ONE_CYCLE) begin
			muxChannel <= pwdata[2:0];
		end else if (cmdWrite && pwdata[4:3] == acm_pkg::CMD_CHAN_PREFIX
			&& seqMode_nxt == acm_pkg::SEQ_TWO_CYCLE) begin
			pendChan_r <= pwdata[2:0];
			pendValid_r <= 1'b1;
		end else if (convEdge) begin
			convChan_r <= muxChannel;
			case (seqMode_nxt)
				acm_pkg::SEQ_STANDARD: muxChannel <= nextEnabled(stdChans_r, muxChannel);
				acm_pkg::SEQ_ADVANCED: begin
					// Slot counts above eight wrap naturally at the 3-bit index
					slotIdx_r <= (4'(slotIdx_r) + 4'h1 >= slotCount) ? 3'h0 : 3'(slotIdx_r + 3'h1);
					muxChannel <= slot_r[(4'(slotIdx_r) + 4'h1 >= slotCount) ? 3'h0 : 3'(slotIdx_r + 3'h1)];
				end
				acm_pkg::SEQ_TWO_CYCLE: begin
					if (pendValid_r) begin
						muxChannel <= pendChan_r;
					end
					pendValid_r <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Threshold alerts with optional hysteresis
	// ****************************************
	logic [5:0] resCfg;
	logic [16:0] upperLow;
	logic [16:0] lowerHigh;
	logic outside;
	logic backInside;
	assign resCfg = seqCtrl_r[acm_pkg::SEQ_STD_BIT] ? chanCfg_r[0] : chanCfg_r[convChan_r];
	assign outside = (resultData > upper_r[convChan_r]) || (resultData < lower_r[convChan_r]);
	assign upperLow = {1'b0, upper_r[convChan_r]} - (setup_r[acm_pkg::SETUP_ALERT_HYST_BIT]
		? {9'h0, hyst_r[convChan_r]} : 17'h0);
	assign lowerHigh = {1'b0, lower_r[convChan_r]} + (setup_r[acm_pkg::SETUP_ALERT_HYST_BIT]
		? {9'h0, hyst_r[convChan_r]} : 17'h0);
	assign backInside = ({1'b0, resultData} <= upperLow) && ({1'b0, resultData} >= lowerHigh);

	always_ff @(posedge ref_clk) begin
		if (regRst) begin
			alertState_r <= 8'h00;
		end else if (resultValid && convMode && resCfg[acm_pkg::CFG_ALERT_BIT]) begin
			if (outside) begin
				alertState_r[convChan_r] <= 1'b1;
			end else if (backInside) begin
				alertState_r[convChan_r] <= 1'b0;
			end
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (regRst) begin
			seqMode <= acm_pkg::SEQ_STANDARD;
			activeConfig <= acm_pkg::CHAN_CFG_RESET;
			alertOut <= 1'b0;
		end else begin
			seqMode <= seqMode_nxt;
			activeConfig <= seqCtrl_r[acm_pkg::SEQ_STD_BIT] ? chanCfg_r[0] : chanCfg_r[muxChannel];
			alertOut <= |alertState_r;
		end
	end

	assign convMode = setup_r[acm_pkg::SETUP_CONV_BIT];
	assign regulatorOn = setup_r[acm_pkg::SETUP_REG_EN_BIT];
	assign autocycleOn = autocycle_r[0];
	assign autocycleRate = autocycle_r[3:1];
endmodule

// ===== acm_config_sva.sv
// Purpose: Port assertions for the configuration and mode control block
// Assumes: One wait state on every APB answer
// Notes: Soft reset may land up to two cycles after its write
`timescale 1ns/1ns
module acm_config_sva (
	// Clock and reset
	input logic ref_clk,
	input logic rst_n,
	// APB
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic pready,
	input logic pslverr,
	// Device controls
	input logic convMode,
	input logic regulatorOn,
	input logic [1:0] seqMode,
	input logic autocycleOn
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	logic acc;
	logic wr;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	// ****
	// Assertions
	// ****
	a_reset_defaults: assert property (
		$rose(rst_n) |-> !convMode && regulatorOn && seqMode == 2'h0 && !autocycleOn)
		else $error("controls not at defaults");
	a_answer_wait: assert property (
		psel && penable && !pready |=> pready)
		else $error("access not answered");
	a_answer_single: assert property (
		pready |=> !pready)
		else $error("answer longer than one cycle");
	a_error_with_ready: assert property (
		pslverr |-> pready)
		else $error("error flag without answer");
	a_conv_enter: assert property (
		wr && !convMode && paddr == acm_pkg::ADDR_SETUP && pwdata[0] |=> convMode)
		else $error("no conversion mode");
	a_conv_refuse: assert property (
		acc && convMode && paddr != acm_pkg::ADDR_STATUS && paddr != acm_pkg::ADDR_COMMAND |-> pslverr)
		else $error("access taken in conversion mode");
	a_cmd_return: assert property (
		wr && convMode && paddr == acm_pkg::ADDR_COMMAND && pwdata[4:0] == acm_pkg::CMD_CONFIG_MODE |=> !convMode)
		else $error("command did not leave conversion mode");
	a_regulator_bit: assert property (
		wr && !convMode && paddr == acm_pkg::ADDR_SETUP |=> regulatorOn == $past(pwdata[1]))
		else $error("regulator not following setup");
	a_autocycle_hold: assert property (
		!wr [*3] |=> $stable(autocycleOn))
		else $error("autocycle changed without a write");
	c_conv_enter: cover property (wr && paddr == acm_pkg::ADDR_SETUP && pwdata[0]);
	c_refused: cover property (acc && pslverr);
	c_conv_leave: cover property ($fell(convMode));
endmodule

bind acm_config_mode_control acm_config_sva u_sva (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .convMode(convMode),
	.regulatorOn(regulatorOn), .seqMode(seqMode), .autocycleOn(autocycleOn)
);

// ===== acm_core_model.sv
// Purpose: Converter core stand-in that starts a conversion and returns a result
// Assumes: startReq is a one-cycle pulse
// Notes: Data is inverted outside its valid cycle so stale values never match
`timescale 1ns/1ns
module acm_core_model (
	// Clock
	input logic ref_clk,
	// Bench requests
	input logic startReq,
	input logic [15:0] sampleValue,
	// Core side
	output logic convStartPin,
	output logic resultValid,
	output logic [15:0] resultData
);
	logic [3:0] stepCount_r = 4'h0;
	always @(posedge ref_clk) begin
		if (startReq) begin
			stepCount_r <= 4'h1;
		end else if (stepCount_r != 4'h0) begin
			stepCount_r <= stepCount_r + 4'h1;
		end
	end
	// Pin held three cycles so the synchroniser cannot miss it
	assign convStartPin = (stepCount_r != 4'h0) && (stepCount_r < 4'h4);
	assign resultValid = stepCount_r == 4'hC;
	assign resultData = resultValid ? sampleValue : ~sampleValue;
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the configuration and mode control block
// Assumes: Core model supplies conversions; clamp pins hold one pattern
// Notes: Expectations come from package constants and field positions
`timescale 1ns/1ns
module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, startReq = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] sampleValue = 16'h0;
	logic [7:0] clampPins = 8'h81;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, rerr, convStartPin, resultValid, convMode, regulatorOn, autocycleOn, alertOut;
	logic [15:0] resultData;
	logic [1:0] seqMode;
	logic [2:0] muxChannel, autocycleRate;
	logic [5:0] activeConfig;
	int errors = 0, cmp_count = 0, cycles = 0;
	localparam logic [31:0] PAT = 32'hA5C30F96;
	always #50 ref_clk = ~ref_clk;
	acm_config_mode_control u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.convStartPin(convStartPin), .clampPins(clampPins), .resultValid(resultValid),
		.resultData(resultData), .convMode(convMode), .regulatorOn(regulatorOn), .seqMode(seqMode),
		.muxChannel(muxChannel), .activeConfig(activeConfig), .autocycleOn(autocycleOn),
		.autocycleRate(autocycleRate), .alertOut(alertOut)
	);
	acm_core_model u_core (
		.ref_clk(ref_clk), .startReq(startReq), .sampleValue(sampleValue),
		.convStartPin(convStartPin), .resultValid(resultValid), .resultData(resultData)
	);
	// ****
	// Tasks
	// ****
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d, logic err = 1'b0);
		xfer(1'b1, a, d);
		chk("write error flag", 32'(err), 32'(rerr));
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] exp, logic err = 1'b0);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("read %h", a), exp, rdata);
		chk("read error flag", 32'(err), 32'(rerr));
	endtask
	// SeqMode and activeConfig follow their sources one cycle late
	task automatic ctl(logic [4:0] exp);
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("controls", 32'(exp), 32'({convMode, regulatorOn, seqMode, autocycleOn}));
	endtask
	task automatic convert(logic [15:0] v);
		@(posedge ref_clk);
		sampleValue <= v;
		startReq <= 1'b1;
		@(posedge ref_clk);
		startReq <= 1'b0;
		do @(posedge ref_clk); while (resultValid !== 1'b1);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			$display("Error run length expected finish seen hang");
			finish_test();
		end
	end
	// ****
	// Tests
	// ****
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		ctl(5'b01000);
		rd(acm_pkg::ADDR_SETUP, 32'(acm_pkg::SETUP_RESET));
		rd(acm_pkg::ADDR_SEQUENCER_CONTROL, 32'(acm_pkg::SEQUENCER_CONTROL_RESET));
		rd(acm_pkg::ADDR_AUTOCYCLE, 32'(acm_pkg::AUTOCYCLE_RESET));
		rd(acm_pkg::BASE_GAIN + 12'h01C, 32'(acm_pkg::GAIN_RESET));
		wr(acm_pkg::ADDR_SCRATCH, PAT);
		rd(acm_pkg::ADDR_SCRATCH, PAT);
		rd(acm_pkg::ADDR_SETUP, 32'(acm_pkg::SETUP_RESET));
		wr(12'h3FC, 32'h1, 1'b1);
		rd(acm_pkg::ADDR_STATUS, 32'h1);
		wr(acm_pkg::ADDR_STATUS, 32'h1);
		rd(acm_pkg::ADDR_STATUS, 32'h0);
		$display("test defaults done");
		wr(acm_pkg::ADDR_SETUP, 32'h0);
		ctl(5'b00000);
		wr(acm_pkg::ADDR_AUTOCYCLE, 32'hB);
		ctl(5'b00001);
		chk("autocycle rate", 32'h5, 32'(autocycleRate));
		wr(acm_pkg::ADDR_AUTOCYCLE, 32'h0);
		wr(acm_pkg::ADDR_SEQUENCER_CONTROL, 32'h3);
		ctl(5'b00010);
		wr(acm_pkg::ADDR_SEQUENCER_CONTROL, 32'h0);
		ctl(5'b00100);
		wr(acm_pkg::BASE_CHAN_CFG + 12'h00C, 32'h35);
		rd(acm_pkg::BASE_CHAN_CFG + 12'h00C, 32'h35);
		wr(acm_pkg::ADDR_SETUP, 32'hB);
		ctl(5'b11110);
		wr(acm_pkg::ADDR_SCRATCH, 32'h0, 1'b1);
		rd(acm_pkg::ADDR_SETUP, 32'h0, 1'b1);
		rd(acm_pkg::ADDR_STATUS, 32'h3);
		wr(acm_pkg::ADDR_COMMAND, 32'h13);
		repeat (2) @(negedge ref_clk);
		chk("channel", 32'h3, 32'(muxChannel));
		chk("active config", 32'h35, 32'(activeConfig));
		wr(acm_pkg::ADDR_COMMAND, 32'(acm_pkg::CMD_CONFIG_MODE));
		ctl(5'b01110);
		rd(acm_pkg::ADDR_SCRATCH, PAT);
		$display("test modes done");
		wr(acm_pkg::ADDR_SOFT_RESET, acm_pkg::SOFT_RESET_KEY);
		repeat (2) @(posedge ref_clk);
		ctl(5'b01000);
		rd(acm_pkg::BASE_CHAN_CFG + 12'h00C, 32'h0);
		wr(acm_pkg::BASE_CHAN_CFG, 32'h01);
		wr(acm_pkg::ADDR_STD_CHANS, 32'h05);
		wr(acm_pkg::BASE_UPPER, 32'h1000);
		wr(acm_pkg::ADDR_SETUP, 32'h3);
		convert(16'h2000);
		chk("channel", 32'h2, 32'(muxChannel));
		chk("active config", 32'h01, 32'(activeConfig));
		chk("alert", 32'h1, 32'(alertOut));
		convert(16'h0800);
		chk("channel", 32'h0, 32'(muxChannel));
		wr(acm_pkg::ADDR_COMMAND, 32'(acm_pkg::CMD_CONFIG_MODE));
		rd(acm_pkg::ADDR_ALERT, 32'h1);
		rd(acm_pkg::ADDR_CLAMP, 32'h81);
		wr(acm_pkg::ADDR_SEQUENCER_CONTROL, 32'h2);
		wr(acm_pkg::BASE_SLOT, 32'h5);
		wr(acm_pkg::BASE_SLOT + 12'h004, 32'h6);
		wr(acm_pkg::ADDR_SETUP, 32'h3);
		convert(16'h0800);
		chk("channel", 32'h6, 32'(muxChannel));
		convert(16'h0800);
		chk("channel", 32'h5, 32'(muxChannel));
		wr(acm_pkg::ADDR_COMMAND, 32'(acm_pkg::CMD_CONFIG_MODE));
		wr(acm_pkg::ADDR_SEQUENCER_CONTROL, 32'h0);
		wr(acm_pkg::ADDR_SETUP, 32'h3);
		wr(acm_pkg::ADDR_COMMAND, 32'h16);
		ctl(5'b11100);
		chk("channel", 32'h0, 32'(muxChannel));
		convert(16'h0800);
		chk("channel", 32'h6, 32'(muxChannel));
		wr(acm_pkg::ADDR_COMMAND, 32'(acm_pkg::CMD_CONFIG_MODE));
		$display("test sequencer done");
		wr(acm_pkg::ADDR_AUTOCYCLE, 32'h1);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		ctl(5'b01000);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		rd(acm_pkg::ADDR_AUTOCYCLE, 32'h0);
		ctl(5'b01000);
		$display("test reset done");
		finish_test();
	end
endmodule
